// ---- src/rbp_params.svh ----
// constants for the reset, brown-out and power-down controller
`ifndef RBP_PARAMS_SVH
`define RBP_PARAMS_SVH

// timing
`define RBP_CLK_PERIOD_NS 8
`define RBP_PIN_FILTER_NS 32000
`define RBP_PIN_FILTER_CYC (`RBP_PIN_FILTER_NS / `RBP_CLK_PERIOD_NS)
`define RBP_BOD_MIN_CYC 20
`define RBP_WDT_HOLD_TICKS 6'h3f
`define RBP_FILT_W 13

// register byte offsets
`define RBP_OFF_RST_SRC 8'h00
`define RBP_OFF_BOD_CTL 8'h04
`define RBP_OFF_PWR_CTL 8'h08
`define RBP_OFF_PORT_SRC 8'h0c
`define RBP_OFF_TMR_STS 8'h10
`define RBP_OFF_WATCHDOG_CONTROL 8'h14
`define RBP_OFF_UNLOCK 8'h18
`define RBP_OFF_INT_STS 8'h1c
`define RBP_OFF_INT_MSK 8'h20

// reset source status fields
`define RBP_RST_POR_BIT 0
`define RBP_RST_PIN_BIT 1
`define RBP_RST_WDT_BIT 2
`define RBP_RST_BOD_BIT 3
`define RBP_RST_SRC_RESET 4'h1

// brown-out control fields
`define RBP_BOD_EXT_BIT 0
`define RBP_BOD_SEL_LO 1
`define RBP_BOD_RSTEN_BIT 3
`define RBP_BOD_IF_BIT 4
`define RBP_BOD_OK_BIT 6
`define RBP_BOD_SEL_HI_BIT 7

// user configuration word fields
`define RBP_CFG_EXT_BIT 23
`define RBP_CFG_SEL_LO 21
`define RBP_CFG_RSTEN_BIT 20
`define RBP_CFG_SEL_HI_BIT 19

// power control fields
`define RBP_PWR_POWER_DOWN_ENABLE_BIT 7
`define RBP_PWR_STATE_LO 8

// timer status, watchdog control
`define RBP_TMR_TIF_BIT 0
`define RBP_TMR_TIMER_WAKE_FLAG_BIT 1
`define RBP_WDT_WKF_BIT 5

// write-protect key, arbitrary value
`define RBP_UNLOCK_KEY 8'h3c

// interrupt status fields
`define RBP_INT_BOD_BIT 0
`define RBP_INT_WAKE_BIT 1
`define RBP_INT_REFUSE_BIT 2
`define RBP_INT_W 3

`endif

// ---- src/rbp_pkg.sv ----
// types for the reset, brown-out and power-down controller
package rbp_pkg;
    typedef enum logic [1:0] {
        PWR_NORMAL = 2'b00,
        PWR_IDLE = 2'b01,
        PWR_PDOWN = 2'b10
    } rbp_pwr_state_t;
endpackage

// ---- src/rbp_deglitch.sv ----
// de-glitch filter: output follows input only after a stable run
module rbp_deglitch #(
    parameter int CNT_W = 13,
    parameter bit INIT = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // sampled input and slow oscillator tick
    input wire logic sample_in,
    input wire logic slow_tick,
    input wire logic use_slow,
    input wire logic [CNT_W-1:0] limit,
    // filtered level
    output logic filtered
);
    logic [CNT_W-1:0] cnt;
    logic [1:0] ticks;

    // flips after limit+1 differing cycles (and two slow edges if use_slow)
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            filtered <= INIT;
            cnt <= '0;
            ticks <= 2'h0;
        end else if (ce) begin
            if (sample_in == filtered) begin
                cnt <= '0;
                ticks <= 2'h0;
            end else if (cnt == limit && (!use_slow || ticks == 2'h2)) begin
                filtered <= sample_in;
                cnt <= '0;
                ticks <= 2'h0;
            end else begin
                if (cnt != limit) begin
                    cnt <= cnt + 1'b1;
                end
                if (slow_tick && ticks != 2'h2) begin
                    ticks <= ticks + 2'h1;
                end
            end
        end
    end
endmodule

// ---- src/rbp_top.sv ----
// reset, brown-out and power-down controller with apb registers
//
// The APB slave port and the address map were left to the implementer.
`include "rbp_params.svh"

// Notes on behaviour
// (R1) pin low over 32 us resets
// (R2) pin high over 32 us releases reset
// (R3) pin reset sets pin reset flag
// (R4) brown-out threshold fields in brown-out control
// (R5) supply low past de-glitch resets if enabled
// (R6) hold brown-out reset until supply recovers stably
// (R7) brown-out defaults load from configuration word
// (R8) idle halts cpu; power-down halts most
// (R9) listed interrupts wake from power-down
// (R10) power-down only on enable plus wfi
// (R11) brown-out flag cleared by writing one
// (R12) port source bit cleared by writing one
// (R13) timer wake and interrupt flags write-one-clear
// (R14) watchdog wake flag cleared only when unlocked
// (R15) reset asserts at once, releases synchronously
// (R16) watchdog reset held 63 slow periods
module rbp_top (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pclken,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins and analog
    input wire logic ext_reset_pin_n,
    input wire logic supply_below_threshold,
    input wire logic slow_internal_osc,
    input wire logic [31:0] user_config_word0,
    output logic [2:0] brownout_threshold_sel,
    output logic brownout_threshold_ext,
    // cpu and wake sources
    input wire logic cpu_wfi,
    input wire logic cpu_irq,
    input wire logic wdt_int,
    input wire logic wdt_timeout,
    input wire logic i2c_int,
    input wire logic timer_int,
    input wire logic uart_int,
    input wire logic [7:0] gpio_int,
    // reset and power outputs
    output logic sys_reset_n,
    output logic cpu_clk_en,
    output logic fast_clk_en,
    output logic flash_en,
    output logic gpio_en,
    output logic periph_en,
    output logic core_regulator_en,
    output logic sram_retain,
    output logic irq
);
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction

    logic pin_q1, pin_q2, sup_q1, sup_q2, slow_q1, slow_q2, slow_q3;
    logic slow_tick, pin_filt, sup_filt, sup_filt_d, pin_filt_d;
    logic bod_event, rst_req, rel_q1, rel_q2, cfg_loaded, bod_hold;
    logic [5:0] wdt_hold;
    logic [3:0] reset_source_status;
    logic [2:0] bod_sel;
    logic bod_ext, brownout_reset_enable, brownout_int_flag;
    logic power_down_enable, unlocked, watchdog_wake_flag;
    logic timer_wake_flag, timer_int_flag;
    logic [7:0] port_int_source;
    logic [`RBP_INT_W-1:0] int_status, int_mask, int_event;
    logic ack, acc, wr, rd, addr_ok, pd_wake, wake_pending, pd_refused, wake_evt;
    logic [31:0] next_prdata;
    rbp_pkg::rbp_pwr_state_t state, next_state;

    // input synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q1 <= 1'b1;
            pin_q2 <= 1'b1;
            sup_q1 <= 1'b1;
            sup_q2 <= 1'b1;
            slow_q1 <= 1'b0;
            slow_q2 <= 1'b0;
            slow_q3 <= 1'b0;
        end else if (pclken) begin
            pin_q1 <= ext_reset_pin_n;
            pin_q2 <= pin_q1;
            sup_q1 <= ~supply_below_threshold;
            sup_q2 <= sup_q1;
            slow_q1 <= slow_internal_osc;
            slow_q2 <= slow_q1;
            slow_q3 <= slow_q2;
        end
    end
    assign slow_tick = slow_q2 & ~slow_q3;

    rbp_deglitch #(.CNT_W(`RBP_FILT_W), .INIT(1'b1)) u_pin_filt (
        .clk(pclk),
        .rst_n(presetn),
        .ce(pclken),
        .sample_in(pin_q2),
        .slow_tick(slow_tick),
        .use_slow(1'b0),
        .limit(`RBP_FILT_W'(`RBP_PIN_FILTER_CYC)), // R1 R2
        .filtered(pin_filt)
    );

    rbp_deglitch #(.CNT_W(`RBP_FILT_W), .INIT(1'b1)) u_bod_filt (
        .clk(pclk),
        .rst_n(presetn),
        .ce(pclken),
        .sample_in(sup_q2),
        .slow_tick(slow_tick),
        .use_slow(1'b1),
        .limit(`RBP_FILT_W'(`RBP_BOD_MIN_CYC)), // R5 R6
        .filtered(sup_filt)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sup_filt_d <= 1'b1;
            pin_filt_d <= 1'b1;
            bod_hold <= 1'b0;
        end else if (pclken) begin
            sup_filt_d <= sup_filt;
            pin_filt_d <= pin_filt;
            // latched so the enable reloaded in reset cannot cut the hold short
            bod_hold <= ~sup_filt & (bod_hold | brownout_reset_enable); // R5 R6
        end
    end
    assign bod_event = sup_filt_d & ~sup_filt;

    // watchdog reset hold counted in slow periods
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_hold <= 6'h00;
        end else if (pclken) begin
            if (wdt_timeout) begin
                wdt_hold <= `RBP_WDT_HOLD_TICKS; // R16
            end else if (slow_tick && wdt_hold != 6'h00) begin
                wdt_hold <= wdt_hold - 6'h01; // R16
            end
        end
    end

    assign rst_req = ~pin_filt | bod_hold | (wdt_hold != 6'h00); // R1 R5 R6

    // release passes two flops, assertion is immediate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rel_q1 <= 1'b0;
            rel_q2 <= 1'b0;
        end else if (pclken) begin
            rel_q1 <= ~rst_req; // R15
            rel_q2 <= rel_q1 & ~rst_req; // R15
        end
    end
    assign sys_reset_n = rel_q2 & ~rst_req; // R15

    // apb handshake: one wait state per access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (pclken) begin
            if (psel && penable && !ack) begin
                ack <= 1'b1;
                prdata <= pwrite ? 32'h0000_0000 : next_prdata;
                pslverr <= ~addr_ok;
            end else begin
                ack <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end
    assign pready = ack & pclken;
    assign acc = psel & penable & ack & addr_ok;
    assign wr = acc & pwrite;
    assign rd = acc & ~pwrite;

    always_comb begin
        next_prdata = 32'h0000_0000;
        addr_ok = 1'b1;
        if (hit(paddr, `RBP_OFF_RST_SRC)) begin
            next_prdata[3:0] = reset_source_status;
        end else if (hit(paddr, `RBP_OFF_BOD_CTL)) begin
            next_prdata[`RBP_BOD_EXT_BIT] = bod_ext;
            next_prdata[`RBP_BOD_SEL_LO +: 2] = bod_sel[1:0];
            next_prdata[`RBP_BOD_RSTEN_BIT] = brownout_reset_enable;
            next_prdata[`RBP_BOD_IF_BIT] = brownout_int_flag;
            next_prdata[`RBP_BOD_OK_BIT] = sup_filt;
            next_prdata[`RBP_BOD_SEL_HI_BIT] = bod_sel[2];
        end else if (hit(paddr, `RBP_OFF_PWR_CTL)) begin
            next_prdata[`RBP_PWR_POWER_DOWN_ENABLE_BIT] = power_down_enable;
            next_prdata[`RBP_PWR_STATE_LO +: 2] = state;
        end else if (hit(paddr, `RBP_OFF_PORT_SRC)) begin
            next_prdata[7:0] = port_int_source;
        end else if (hit(paddr, `RBP_OFF_TMR_STS)) begin
            next_prdata[`RBP_TMR_TIF_BIT] = timer_int_flag;
            next_prdata[`RBP_TMR_TIMER_WAKE_FLAG_BIT] = timer_wake_flag;
        end else if (hit(paddr, `RBP_OFF_WATCHDOG_CONTROL)) begin
            next_prdata[`RBP_WDT_WKF_BIT] = watchdog_wake_flag;
        end else if (hit(paddr, `RBP_OFF_UNLOCK)) begin
            next_prdata[0] = unlocked;
        end else if (hit(paddr, `RBP_OFF_INT_STS)) begin
            next_prdata[`RBP_INT_W-1:0] = int_status;
        end else if (hit(paddr, `RBP_OFF_INT_MSK)) begin
            next_prdata[`RBP_INT_W-1:0] = int_mask;
        end else begin
            addr_ok = 1'b0;
        end
    end

    // reset source flags survive system reset, cleared by writing one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_source_status <= `RBP_RST_SRC_RESET;
        end else if (pclken) begin
            if (wr && hit(paddr, `RBP_OFF_RST_SRC)) begin
                reset_source_status <= reset_source_status & ~pwdata[3:0];
            end
            if (pin_filt_d && !pin_filt) begin
                reset_source_status[`RBP_RST_PIN_BIT] <= 1'b1; // R3
            end
            if (wdt_timeout) begin
                reset_source_status[`RBP_RST_WDT_BIT] <= 1'b1;
            end
            if (bod_event && brownout_reset_enable) begin
                reset_source_status[`RBP_RST_BOD_BIT] <= 1'b1;
            end
        end
    end

    // brown-out settings, reloaded from the configuration word in reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_loaded <= 1'b0;
            bod_sel <= 3'h0;
            bod_ext <= 1'b0;
            brownout_reset_enable <= 1'b0;
        end else if (pclken) begin
            cfg_loaded <= 1'b1;
            if (rst_req || !cfg_loaded) begin
                bod_ext <= user_config_word0[`RBP_CFG_EXT_BIT]; // R7
                bod_sel[1:0] <= user_config_word0[`RBP_CFG_SEL_LO +: 2]; // R7
                bod_sel[2] <= user_config_word0[`RBP_CFG_SEL_HI_BIT]; // R7
                brownout_reset_enable <= user_config_word0[`RBP_CFG_RSTEN_BIT]; // R7
            end else if (wr && hit(paddr, `RBP_OFF_BOD_CTL)) begin
                bod_ext <= pwdata[`RBP_BOD_EXT_BIT]; // R4
                bod_sel[1:0] <= pwdata[`RBP_BOD_SEL_LO +: 2]; // R4
                bod_sel[2] <= pwdata[`RBP_BOD_SEL_HI_BIT]; // R4
                brownout_reset_enable <= pwdata[`RBP_BOD_RSTEN_BIT]; // R5
            end
        end
    end
    assign brownout_threshold_sel = bod_sel;
    assign brownout_threshold_ext = bod_ext;

    // wake flags; a set in the same cycle beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brownout_int_flag <= 1'b0;
            timer_int_flag <= 1'b0;
            timer_wake_flag <= 1'b0;
            watchdog_wake_flag <= 1'b0;
            unlocked <= 1'b0;
            power_down_enable <= 1'b0;
            int_mask <= '0;
        end else if (pclken) begin
            if (bod_event) begin
                brownout_int_flag <= 1'b1;
            end else if (wr && hit(paddr, `RBP_OFF_BOD_CTL) && pwdata[`RBP_BOD_IF_BIT]) begin
                brownout_int_flag <= 1'b0; // R11
            end
            if (timer_int) begin
                timer_int_flag <= 1'b1;
            end else if (wr && hit(paddr, `RBP_OFF_TMR_STS) && pwdata[`RBP_TMR_TIF_BIT]) begin
                timer_int_flag <= 1'b0; // R13
            end
            if (timer_int && state == rbp_pkg::PWR_PDOWN) begin
                timer_wake_flag <= 1'b1;
            end else if (wr && hit(paddr, `RBP_OFF_TMR_STS) && pwdata[`RBP_TMR_TIMER_WAKE_FLAG_BIT]) begin
                timer_wake_flag <= 1'b0; // R13
            end
            if (wdt_int && state == rbp_pkg::PWR_PDOWN) begin
                watchdog_wake_flag <= 1'b1;
            end else if (wr && hit(paddr, `RBP_OFF_WATCHDOG_CONTROL) && unlocked
                         && pwdata[`RBP_WDT_WKF_BIT]) begin
                watchdog_wake_flag <= 1'b0; // R14
            end
            if (wr && hit(paddr, `RBP_OFF_UNLOCK)) begin
                unlocked <= (pwdata[7:0] == `RBP_UNLOCK_KEY); // R14
            end
            if (wr && hit(paddr, `RBP_OFF_PWR_CTL)) begin
                power_down_enable <= pwdata[`RBP_PWR_POWER_DOWN_ENABLE_BIT];
            end
            if (wr && hit(paddr, `RBP_OFF_INT_MSK)) begin
                int_mask <= pwdata[`RBP_INT_W-1:0];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_port
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    port_int_source[g] <= 1'b0;
                end else if (pclken) begin
                    if (gpio_int[g]) begin
                        port_int_source[g] <= 1'b1;
                    end else if (wr && hit(paddr, `RBP_OFF_PORT_SRC) && pwdata[g]) begin
                        port_int_source[g] <= 1'b0; // R12
                    end
                end
            end
        end
    endgenerate

    // power mode sequencing
    assign pd_wake = wdt_int | i2c_int | timer_int | uart_int | bod_event | (|gpio_int); // R9
    assign wake_pending = brownout_int_flag | (|port_int_source) | timer_int_flag
                          | timer_wake_flag | watchdog_wake_flag; // R11 R12 R13 R14
    assign pd_refused = cpu_wfi & power_down_enable & wake_pending
                        & (state == rbp_pkg::PWR_NORMAL);

    always_comb begin
        next_state = state;
        unique case (state)
            rbp_pkg::PWR_NORMAL: begin
                if (cpu_wfi && power_down_enable && !wake_pending) begin
                    next_state = rbp_pkg::PWR_PDOWN; // R10
                end else if (cpu_wfi && !power_down_enable) begin
                    next_state = rbp_pkg::PWR_IDLE; // R8
                end
            end
            rbp_pkg::PWR_IDLE: begin
                if (cpu_irq || pd_wake) begin
                    next_state = rbp_pkg::PWR_NORMAL;
                end
            end
            rbp_pkg::PWR_PDOWN: begin
                if (pd_wake) begin
                    next_state = rbp_pkg::PWR_NORMAL; // R9
                end
            end
            default: next_state = rbp_pkg::PWR_NORMAL;
        endcase
        if (rst_req) begin
            next_state = rbp_pkg::PWR_NORMAL;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= rbp_pkg::PWR_NORMAL;
        end else if (pclken) begin
            state <= next_state;
        end
    end
    assign wake_evt = (state == rbp_pkg::PWR_PDOWN) && (next_state == rbp_pkg::PWR_NORMAL);

    // clock and unit enables from the mode; regulator and sram retention are tied on
    assign cpu_clk_en = (state == rbp_pkg::PWR_NORMAL); // R8
    assign fast_clk_en = (state != rbp_pkg::PWR_PDOWN); // R8
    assign flash_en = fast_clk_en;
    assign gpio_en = fast_clk_en;
    assign periph_en = fast_clk_en;
    assign core_regulator_en = 1'b1; // R8
    assign sram_retain = 1'b1;

    // interrupt status, cleared by a read, set wins
    assign int_event = {pd_refused, wake_evt, bod_event};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status <= '0;
        end else if (pclken) begin
            if (rd && hit(paddr, `RBP_OFF_INT_STS)) begin
                int_status <= int_event;
            end else begin
                int_status <= int_status | int_event;
            end
        end
    end
    assign irq = |(int_status & int_mask);
endmodule

// ---- dv/rbp_partner.sv ----
// model of the reset pin driver, supply comparator and slow oscillator
module rbp_partner #(
    parameter int SLOW_HALF = 16
) (
    // clock and bench controls
    input wire logic pclk,
    input wire logic hold_pin_low,
    input wire logic make_supply_low,
    // lines toward the controller
    output logic ext_reset_pin_n,
    output logic supply_below_threshold,
    output logic slow_internal_osc
);
    timeunit 1ns;
    timeprecision 1ps;
    bit slow_q;
    int slow_cnt;
    // levels pass straight through; the slow oscillator runs free
    assign ext_reset_pin_n = ~hold_pin_low;
    assign supply_below_threshold = make_supply_low;
    assign slow_internal_osc = slow_q;
    always @(posedge pclk) begin
        slow_cnt <= (slow_cnt == SLOW_HALF - 1) ? 0 : slow_cnt + 1;
        if (slow_cnt == SLOW_HALF - 1) begin
            slow_q <= ~slow_q;
        end
    end
endmodule

// ---- dv/rbp_monitor.sv ----
// assertion checker for the reset, brown-out and power-down controller
module rbp_monitor (
    // clock, reset, apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pclken,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // pins and wake sources
    input wire logic ext_reset_pin_n,
    input wire logic [31:0] user_config_word0,
    input wire logic [2:0] brownout_threshold_sel,
    input wire logic brownout_threshold_ext,
    input wire logic cpu_wfi,
    input wire logic cpu_irq,
    input wire logic wdt_int,
    input wire logic wdt_timeout,
    input wire logic i2c_int,
    input wire logic timer_int,
    input wire logic uart_int,
    input wire logic [7:0] gpio_int,
    // reset and power outputs
    input wire logic sys_reset_n,
    input wire logic cpu_clk_en,
    input wire logic fast_clk_en,
    input wire logic flash_en,
    input wire logic gpio_en,
    input wire logic periph_en,
    input wire logic core_regulator_en,
    input wire logic sram_retain
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    int low_run;
    int high_run;
    bit ever_low;
    logic wake;
    logic [3:0] cfg_bod;
    assign wake = wdt_int | i2c_int | timer_int | uart_int | (|gpio_int);
    assign cfg_bod = {user_config_word0[19], user_config_word0[22:21], user_config_word0[23]};
    always_ff @(posedge pclk) begin
        low_run <= ext_reset_pin_n ? 0 : low_run + 1;
        high_run <= ext_reset_pin_n ? high_run + 1 : 0;
        ever_low <= ever_low | ~ext_reset_pin_n;
    end
    a_apb_one_wait: assert property (psel && penable && !pready && pclken ##1 pclken |-> pready)
        else $error("late pready");
    a_apb_ack_pulse: assert property (pready |-> psel && penable ##1 !pready)
        else $error("stray pready");
    a_slverr_ack: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_pin_assert: assert property (low_run == 4010 |-> !sys_reset_n)
        else $error("no pin reset");
    a_pin_release: assert property ($rose(sys_reset_n) |-> !ever_low || high_run >= 4001)
        else $error("early pin release");
    a_cfg_reload: assert property (!sys_reset_n && !$past(sys_reset_n) && pclken |=>
        {brownout_threshold_sel, brownout_threshold_ext} == $past(cfg_bod))
        else $error("no config reload");
    a_pd_domains: assert property (core_regulator_en && sram_retain && flash_en == fast_clk_en
        && gpio_en == fast_clk_en && periph_en == fast_clk_en && (fast_clk_en || !cpu_clk_en))
        else $error("bad domain enables");
    a_pd_entry: assert property ($fell(fast_clk_en) |-> $past(cpu_wfi))
        else $error("power-down without wfi");
    a_pd_wake: assert property (!fast_clk_en && wake && pclken |-> ##[1:3] fast_clk_en)
        else $error("no wake from power-down");
    a_idle_wake: assert property (!cpu_clk_en && fast_clk_en && cpu_irq && pclken
        |-> ##[1:3] cpu_clk_en)
        else $error("no wake from idle");
    a_wdt_hold: assert property (wdt_timeout && pclken |=> !sys_reset_n [*8])
        else $error("watchdog hold short");
endmodule

bind rbp_top rbp_monitor rbp_monitor_i (.*);

// ---- dv/tb_rbp_top.sv ----
// testbench for the reset, brown-out and power-down controller
module tb_rbp_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = '0, presetn = '0, pclken = '1, psel = '0, penable = '0, pwrite = '0;
    logic hold_pin_low = '0, make_supply_low = '0, cpu_wfi = '0, cpu_irq = '0, wdt_int = '0;
    logic wdt_timeout = '0, i2c_int = '0, timer_int = '0, uart_int = '0;
    logic [7:0] paddr = '0, gpio_int = '0;
    logic [31:0] pwdata = '0, user_config_word0 = 32'h00a80000;
    logic [31:0] prdata;
    logic pready, pslverr, ext_reset_pin_n, supply_below_threshold, slow_internal_osc;
    logic [2:0] brownout_threshold_sel;
    logic brownout_threshold_ext, sys_reset_n, cpu_clk_en, fast_clk_en, flash_en, gpio_en;
    logic periph_en, core_regulator_en, sram_retain, irq, err;
    logic [31:0] rd;
    int mismatches = 0;
    int checked = 0;

    rbp_top rbp_top_i (.*);
    rbp_partner #(.SLOW_HALF(16)) rbp_partner_i (.*);

    initial forever #4 pclk = ~pclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= '1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= '1;
        // pready and data are looked at mid-cycle, the transfer ends at the next edge
        do @(negedge pclk); while (pready !== 1'b1 && ++n < 50);
        if (pready !== 1'b1) mismatches++;
        rd = prdata;
        err = pslverr;
        @(posedge pclk);
        psel <= '0;
        penable <= '0;
    endtask

    // one-cycle pulse on the chosen source
    task automatic fire(input int s);
        @(posedge pclk);
        case (s)
            0: i2c_int <= '1;
            1: uart_int <= '1;
            2: timer_int <= '1;
            3: gpio_int[2] <= '1;
            4: wdt_int <= '1;
            5: cpu_wfi <= '1;
            6: cpu_irq <= '1;
            default: wdt_timeout <= '1;
        endcase
        @(posedge pclk);
        {cpu_wfi, cpu_irq, wdt_int, wdt_timeout, i2c_int, timer_int, uart_int, gpio_int} <= '0;
    endtask

    task automatic sc_regs();
        apb(0, 8'h00, 0);
        check(rd, 32'h1);
        apb(0, 8'h04, 0);
        check(rd, 32'hc3);
        check(32'({brownout_threshold_sel, brownout_threshold_ext}), 32'hb);
        apb(0, 8'h40, 0);
        check(32'(err), 32'h1);
    endtask

    task automatic sc_pin();
        hold_pin_low <= '1;
        cyc(3000);
        hold_pin_low <= '0;
        cyc(20);
        check(32'(sys_reset_n), 32'h1);
        hold_pin_low <= '1;
        cyc(4100);
        check(32'(sys_reset_n), 32'h0);
        hold_pin_low <= '0;
        cyc(3000);
        check(32'(sys_reset_n), 32'h0);
        cyc(1100);
        check(32'(sys_reset_n), 32'h1);
        apb(0, 8'h00, 0);
        check(rd, 32'h3);
    endtask

    task automatic bod_low(input int n);
        make_supply_low <= '1;
        cyc(n);
    endtask

    task automatic sc_bod();
        apb(1, 8'h20, 32'h1);
        bod_low(10);
        make_supply_low <= '0;
        cyc(100);
        check(32'(irq), 32'h0);
        bod_low(100);
        check(32'(sys_reset_n), 32'h1);
        check(32'(irq), 32'h1);
        apb(0, 8'h04, 0);
        check(rd, 32'h93);
        apb(0, 8'h1c, 0);
        check(rd, 32'h1);
        cyc(1);
        check(32'(irq), 32'h0);
        make_supply_low <= '0;
        cyc(100);
        apb(1, 8'h04, 32'h9b);
        apb(0, 8'h04, 0);
        check(rd, 32'hcb);
        bod_low(100);
        check(32'(sys_reset_n), 32'h0);
        make_supply_low <= '0;
        cyc(10);
        check(32'(sys_reset_n), 32'h0);
        cyc(100);
        check(32'(sys_reset_n), 32'h1);
        apb(0, 8'h00, 0);
        check(rd, 32'hb);
        apb(0, 8'h04, 0);
        check(32'(rd[3]), 32'h0);
        apb(1, 8'h04, 32'h93);
        apb(0, 8'h1c, 0);
    endtask

    task automatic sc_power();
        apb(1, 8'h20, 32'h2);
        apb(1, 8'h08, 32'h80);
        for (int s = 0; s < 5; s++) begin
            fire(5);
            cyc(2);
            check(32'({cpu_clk_en, fast_clk_en, core_regulator_en, sram_retain}), 32'h3);
            fire(s);
            cyc(3);
            check(32'({cpu_clk_en, fast_clk_en, irq}), 32'h7);
            apb(0, 8'h1c, 0);
            check(rd, 32'h2);
            apb(0, 8'h10, 0);
            check(rd, (s == 2) ? 32'h3 : 32'h0);
            apb(1, 8'h10, 32'h3);
            apb(0, 8'h0c, 0);
            check(rd, (s == 3) ? 32'h4 : 32'h0);
            apb(1, 8'h0c, 32'hff);
        end
        apb(0, 8'h10, 0);
        check(rd, 32'h0);
        fire(5);
        cyc(2);
        check(32'({fast_clk_en, irq}), 32'h2);
        apb(0, 8'h1c, 0);
        check(rd, 32'h4);
        apb(1, 8'h14, 32'h20);
        apb(0, 8'h14, 0);
        check(32'(rd[5]), 32'h1);
        apb(1, 8'h18, 32'h3c);
        apb(1, 8'h14, 32'h20);
        apb(0, 8'h14, 0);
        check(32'(rd[5]), 32'h0);
        apb(1, 8'h08, 32'h0);
        fire(5);
        cyc(2);
        check(32'({cpu_clk_en, fast_clk_en, flash_en}), 32'h3);
        apb(0, 8'h08, 0);
        check(rd, 32'h100);
        fire(6);
        cyc(3);
        check(32'(cpu_clk_en), 32'h1);
    endtask

    task automatic sc_wdt();
        fire(7);
        cyc(1900);
        check(32'(sys_reset_n), 32'h0);
        cyc(250);
        check(32'(sys_reset_n), 32'h1);
        apb(0, 8'h00, 0);
        check(32'(rd[2]), 32'h1);
    endtask

    task automatic close_out();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        cyc(5);
        presetn <= '1;
        cyc(4);
        sc_regs();
        sc_pin();
        sc_bod();
        sc_power();
        sc_wdt();
        close_out();
    end

    initial begin
        cyc(40000);
        mismatches++;
        close_out();
    end
endmodule
